// [pkg/aps_params.svh]
// Constants for the analog pin select registers.
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH
`define APS_PAGE          8'h00
`define APS_P4_ADDR       8'hA5
`define APS_P5_ADDR       8'hA6
`define APS_P3_ADDR       8'hA4
`define APS_P4_RESET      8'h00
`define APS_P5_RESET      3'h0
`define APS_P3_RESET      1'h0
`define APS_P5_WIDTH      3
`define APS_P4_WIDTH      8
`define APS_P3_WIDTH      1
`define APS_DATA_WIDTH    8
`endif

// [pkg/aps_pkg.sv]
// Types shared by the analog pin select registers.
package aps_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } aps_sfr_req_t;

  typedef struct packed {
    logic       p3_0;
    logic [7:0] p4;
    logic [2:0] p5;
  } aps_route_t;
endpackage : aps_pkg

// [src/aps_pin_select.sv]
// Analog pin select registers on the special-function-register bus.
`include "aps_params.svh"
module aps_pin_select (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Register bus
  input  wire aps_pkg::aps_sfr_req_t sfr_req,
  output      logic [7:0]          sfr_rdata,
  output      logic                sfr_hit,
  // Router controls
  output      aps_pkg::aps_route_t route
);
  import aps_pkg::*;

  // Widths of the three select groups held in this block.
  localparam int unsigned P3_BITS   = `APS_P3_WIDTH;
  localparam int unsigned P4_BITS   = `APS_P4_WIDTH;
  localparam int unsigned P5_BITS   = `APS_P5_WIDTH;
  localparam int unsigned DATA_BITS = `APS_DATA_WIDTH;
  localparam int unsigned SEL_BITS  = P3_BITS + P4_BITS + P5_BITS;
  localparam int unsigned P3_PAD    = DATA_BITS - P3_BITS;
  localparam int unsigned P5_PAD    = DATA_BITS - P5_BITS;

  // Decoded bus strobes.
  logic                 on_page;
  logic                 wr_p3;
  logic                 wr_p4;
  logic                 wr_p5;
  logic                 rd_p3;
  logic                 rd_p4;
  logic                 rd_p5;
  logic                 rd_any;
  logic                 rd_unmapped;

  // Flat view of all pin selects: entry 0 is pin 3.0, entries 1 to 8 are
  // pins 4.0 to 4.7 and entries 9 to 11 are pins 5.0 to 5.2.
  logic [SEL_BITS-1:0]  sel;
  logic [SEL_BITS-1:0]  sel_wr;
  logic [SEL_BITS-1:0]  sel_data;
  logic [SEL_BITS-1:0]  next_sel;

  // Read path.
  logic [DATA_BITS-1:0] next_rdata;
  logic                 next_hit;

  // A strobe on any other page belongs to a register that shares the address,
  // so the page match gates every write and read here.
  always_comb
  begin
    on_page     = (sfr_req.page == `APS_PAGE);
    wr_p3       = 1'b0;
    wr_p4       = 1'b0;
    wr_p5       = 1'b0;
    rd_p3       = 1'b0;
    rd_p4       = 1'b0;
    rd_p5       = 1'b0;
    rd_unmapped = 1'b0;
    if (on_page)
    begin
      wr_p3       = sfr_req.wr && (sfr_req.addr == `APS_P3_ADDR);
      wr_p4       = sfr_req.wr && (sfr_req.addr == `APS_P4_ADDR);
      wr_p5       = sfr_req.wr && (sfr_req.addr == `APS_P5_ADDR);
      rd_p3       = sfr_req.rd && (sfr_req.addr == `APS_P3_ADDR);
      rd_p4       = sfr_req.rd && (sfr_req.addr == `APS_P4_ADDR);
      rd_p5       = sfr_req.rd && (sfr_req.addr == `APS_P5_ADDR);
      rd_unmapped = sfr_req.rd && !(rd_p3 || rd_p4 || rd_p5);
    end
    rd_any = rd_p3 || rd_p4 || rd_p5;
  end

  assign sel = {route.p5, route.p4, route.p3_0};

  // Each select bit takes its write data bit when its register is written,
  // and otherwise keeps its value.
  genvar g;
  generate
    for (g = 0; g < SEL_BITS; g++)
    begin : g_sel_bit
      if (g < P3_BITS)
      begin : g_p3
        // Only bit 0 of the port 3 register lives here; the rest is kept elsewhere.
        assign sel_wr[g]   = wr_p3;
        assign sel_data[g] = sfr_req.wdata[g];
      end
      else if (g < P3_BITS + P4_BITS)
      begin : g_p4
        assign sel_wr[g]   = wr_p4;
        assign sel_data[g] = sfr_req.wdata[g - P3_BITS];
      end
      else
      begin : g_p5
        // Only the low bits are stored; reserved write data is dropped.
        assign sel_wr[g]   = wr_p5;
        assign sel_data[g] = sfr_req.wdata[g - P3_BITS - P4_BITS];
      end
      assign next_sel[g] = sel_wr[g] ? sel_data[g] : sel[g];
    end
  endgenerate

  // Read data holds until the next read on this page, so a slow reader can
  // pick it up later; the hit flag is a single-cycle pulse.
  always_comb
  begin
    next_rdata = sfr_rdata;
    next_hit   = rd_any;
    if (rd_p3)
    begin
      next_rdata = {{P3_PAD{1'b0}}, route.p3_0};
    end
    else if (rd_p4)
    begin
      next_rdata = route.p4;
    end
    else if (rd_p5)
    begin
      // Reserved bits are not stored, so they always read as zero.
      next_rdata = {{P5_PAD{1'b0}}, route.p5};
    end
    else if (rd_unmapped)
    begin
      next_rdata = {DATA_BITS{1'b0}};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      route.p3_0 <= `APS_P3_RESET;
      route.p4   <= `APS_P4_RESET;
      route.p5   <= `APS_P5_RESET;
      sfr_rdata  <= 8'h00;
      sfr_hit    <= 1'b0;
    end
    else
    begin
      route.p3_0 <= next_sel[0];
      route.p4   <= next_sel[P3_BITS +: P4_BITS];
      route.p5   <= next_sel[P3_BITS + P4_BITS +: P5_BITS];
      sfr_rdata  <= next_rdata;
      sfr_hit    <= next_hit;
    end
  end
endmodule : aps_pin_select

// [tb/aps_pin_select_asserts.sv]
// Checker for the pin select registers.
`include "aps_params.svh"
module aps_pin_select_asserts (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // Register bus
  input wire aps_pkg::aps_sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  sfr_hit,
  // Router controls
  input wire aps_pkg::aps_route_t   route
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire       w = sfr_req.wr && (sfr_req.page == `APS_PAGE);
  wire       r = sfr_req.rd && !sfr_req.wr && (sfr_req.page == `APS_PAGE);
  wire [7:0] a = sfr_req.addr;
  wire [7:0] d = sfr_req.wdata;
  a_p3_set: assert property (
    w && a == `APS_P3_ADDR |=> route.p3_0 == $past(d[0]))
    else $error("port 3 write not applied");
  a_p4_set: assert property (
    w && a == `APS_P4_ADDR |=> route.p4 == $past(d))
    else $error("port 4 write not applied");
  a_p5_set: assert property (
    w && a == `APS_P5_ADDR |=> route.p5 == $past(d[2:0]))
    else $error("port 5 write not applied");
  a_idle_hold: assert property (
    !w |=> $stable(route))
    else $error("selects moved without a write");
  a_p4_read: assert property (
    r && a == `APS_P4_ADDR |=> sfr_hit && sfr_rdata == $past(route.p4))
    else $error("port 4 read wrong");
  a_no_hit: assert property (
    sfr_req.rd && a == 8'hA7 |=> !sfr_hit)
    else $error("unmapped read gave a hit");
  a_off_page: assert property (
    sfr_req.wr && sfr_req.page != `APS_PAGE |=> $stable(route))
    else $error("write on another page applied");
  a_p5_rsvd_zero: assert property (
    r && a == `APS_P5_ADDR |=> sfr_hit && sfr_rdata[7:3] == 5'h00)
    else $error("port 5 reserved bits read nonzero");
endmodule : aps_pin_select_asserts
bind aps_pin_select aps_pin_select_asserts u_chk (.*);

// [tb/aps_pin_select_bench.sv]
// Bench for the pin select registers.
module aps_pin_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk   = 1'b0;
  logic                  reset = 1'b1;
  logic [7:0]            q;
  logic                  hit;
  aps_pkg::aps_sfr_req_t req   = '0;
  aps_pkg::aps_route_t   route;
  int                    n_fail       = 0;
  int                    total_checks = 0;

  always #10 clk = ~clk;

  aps_pin_select u_dut (
    .clk       (clk),
    .reset     (reset),
    .sfr_req   (req),
    .sfr_rdata (q),
    .sfr_hit   (hit),
    .route     (route)
  );

  task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  // Strobe is raised after a falling edge, taken at the rising edge, dropped at the next fall.
  task access(input logic w, input logic [7:0] page, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{a, page, d, w, !w};
    @(negedge clk);
    req = '0;
  endtask : access

  // A write is judged on the whole route word, so stray bits in other ports show up too.
  task wr(input logic [7:0] page, input logic [7:0] a, input logic [7:0] d,
          input logic [11:0] e);
    access(1'b1, page, a, d);
    check("route", route, e);
  endtask : wr

  // The hit pulse stands for one cycle, so it is looked at in the cycle after the strobe.
  task rd(input logic [7:0] a, input logic [7:0] e, input logic eh);
    access(1'b0, 8'h00, a, 8'h00);
    check("rdata", 12'(q), 12'(e));
    check("hit", 12'(hit), 12'(eh));
  endtask : rd

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // The tests need well under 2000 ns; a hang is counted as a mismatch.
  initial
  begin
    #20000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    rd(8'hA6, 8'h00, 1'b1);
    rd(8'hA5, 8'h00, 1'b1);
    rd(8'hA4, 8'h00, 1'b1);
    wr(8'h00, 8'hA5, 8'hA5, 12'h528);
    wr(8'h00, 8'hA6, 8'h07, 12'h52F);
    wr(8'h00, 8'hA4, 8'h01, 12'hD2F);
    wr(8'h01, 8'hA5, 8'h00, 12'hD2F);
    rd(8'hA5, 8'hA5, 1'b1);
    rd(8'hA6, 8'h07, 1'b1);
    rd(8'hA4, 8'h01, 1'b1);
    rd(8'hA7, 8'h00, 1'b0);
    wr(8'h00, 8'hA4, 8'hFE, 12'h52F);
    wr(8'h00, 8'hA5, 8'h00, 12'h007);
    wr(8'h00, 8'hA6, 8'h00, 12'h000);
    wr(8'h00, 8'hA5, 8'h5A, 12'h2D0);
    @(negedge clk);
    reset = 1'b1;
    @(negedge clk);
    check("route", route, 12'h000);
    reset = 1'b0;
    rd(8'hA5, 8'h00, 1'b1);
    wrap_up();
  end
endmodule : aps_pin_select_bench
